// *** verilog/sbc_wake_params.svh ***
// constants for the wake, inhibit and reset control block
// Functional notes
// - recessive bus state is logic high and the idle state.
// - dominant is logic low; any dominant node overrides recessive.
// - low power standby puts bus terminals in a weak-to-ground third state.
// - test mode routes internal transmit and receive nodes to external pins.
// - frames and configuration travel over the serial interface to the host.
// - regulator enable active in all modes but sleep; high-z in sleep.
// - config bit 9 at 0x0800 set to one suppresses regulator enable.
// - after reset local wake triggers on either edge.
// - config bits 31:30 at 0x0800 select wake edge mode.
// - supply regulator off in sleep, on in every other mode.
// - valid reset restores defaults and enters standby.
// - reset in normal or standby keeps enable and wake request steady; the code raises the wake request on every pin reset, even when it was cleared.
// - reset in sleep enters standby and turns both outputs on.
// - wake request asserts on bus wake, local wake or power on.
`ifndef SBC_WAKE_PARAMS_SVH
`define SBC_WAKE_PARAMS_SVH
`define CFG_ADDR 16'h0800
`define CFG_INH_DIS_BIT 9
`define CFG_EDGE_HI 31
`define CFG_EDGE_LO 30
`define CFG_EDGE_RST 2'h3
`define CFG_INH_DIS_RST 1'h0
`define CLK_MHZ 200
`define PULSE_NS 1000
`define PULSE_CYC ((`PULSE_NS * `CLK_MHZ + 999) / 1000)
`define ACCESS_WAIT_US 700
`define ACCESS_WAIT_CYC (`ACCESS_WAIT_US * `CLK_MHZ)
`endif

// *** verilog/sbc_wake_pkg.sv ***
// types shared by the wake, inhibit and reset control block
package sbc_wake_pkg;
   typedef enum logic [3:0] {
      MODE_NORMAL = 4'h1,
      MODE_STANDBY = 4'h2,
      MODE_SLEEP = 4'h4,
      MODE_TEST = 4'h8
   } mode_t;
   // edge select encoding is ours: 00 off, 01 rise, 10 fall, 11 both
   typedef enum logic [1:0] {
      EDGE_OFF = 2'h0,
      EDGE_RISE = 2'h1,
      EDGE_FALL = 2'h2,
      EDGE_BOTH = 2'h3
   } edge_sel_t;
   typedef struct packed {
      logic [1:0] edge_sel;
      logic inh_disable;
      logic test_en;
      logic test_phy;
   } cfg_t;
   typedef struct packed {
      logic txd;
      logic rxd;
   } node_pair_t;
endpackage : sbc_wake_pkg

// *** verilog/wake_edge_detect.sv ***
// local wake edge detector with selectable edge sense
module wake_edge_detect (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // wake pin and selection
   input wire logic wake_pin,
   input wire logic [1:0] edge_sel,
   // result
   output logic local_rouse_event
);
   logic wake_q;
   logic armed;
   wire rise = wake_pin & ~wake_q;
   wire fall = ~wake_pin & wake_q;
   wire hit = armed & ((edge_sel[0] & rise) | (edge_sel[1] & fall));

   // armed one cycle after reset so the captured pin level is real
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         wake_q <= 1'h0;
         armed <= 1'h0;
         local_rouse_event <= 1'h0;
      end else begin
         wake_q <= wake_pin;
         armed <= 1'h1;
         local_rouse_event <= hit;
      end
   end
endmodule : wake_edge_detect

// *** verilog/sbc_wake_inhibit_reset_control.sv ***
// mode, inhibit, wake request and reset pin control
`include "sbc_wake_params.svh"
module sbc_wake_inhibit_reset_control #(
   parameter int PULSE_CYC = `PULSE_CYC,
   parameter int ACCESS_WAIT_CYC = `ACCESS_WAIT_CYC
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // reset pin from host, active high
   input wire logic reset_pin,
   // mode and configuration from the serial block
   input wire logic mode_wr,
   input wire sbc_wake_pkg::mode_t mode_req,
   input wire logic cfg_wr,
   input wire logic [31:0] cfg_data,
   // wake sources
   input wire logic wake_pin,
   input wire logic bus_wup,
   input wire logic wake_clear,
   // internal nodes
   input wire sbc_wake_pkg::node_pair_t ctrl_node,
   input wire sbc_wake_pkg::node_pair_t phy_node,
   input wire logic test_in_pin,
   // bus driver
   output logic bus_drive_dom,
   output logic bus_bias_weak,
   output logic bus_rx,
   input wire logic bus_level,
   // test pins
   output logic test_out_pin,
   output logic test_out_oe,
   // supplies and wake request
   output logic regulator_enable_out,
   output logic regulator_enable_oe,
   output logic ldo_supply_out,
   output logic rouse_request_n,
   output logic spi_ready,
   output sbc_wake_pkg::mode_t mode
);
   logic rst_s1, rst_s2;
   logic pin_q;
   logic [$clog2(PULSE_CYC+1)-1:0] pulse_cnt;
   logic [$clog2(ACCESS_WAIT_CYC+1)-1:0] wait_cnt;
   sbc_wake_pkg::cfg_t cfg;
   sbc_wake_pkg::mode_t next_mode;
   logic wake_latched;
   logic local_rouse_event;

   // reset release through two flops
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_s1 <= 1'h0;
         rst_s2 <= 1'h0;
      end else begin
         rst_s1 <= 1'h1;
         rst_s2 <= rst_s1;
      end
   end

   wake_edge_detect u_wake (
      .sys_clk(sys_clk),
      .rst_b(rst_s2),
      .wake_pin(wake_pin),
      .edge_sel(cfg.edge_sel),
      .local_rouse_event(local_rouse_event)
   );

   // reset pulse accepted on falling edge after enough high cycles
   wire pulse_long = (pulse_cnt >= PULSE_CYC[$bits(pulse_cnt)-1:0]);
   wire pin_reset = pin_q & ~reset_pin & pulse_long;
   wire in_sleep = (mode == sbc_wake_pkg::MODE_SLEEP);
   wire is_test = (mode == sbc_wake_pkg::MODE_TEST) & cfg.test_en;

   always_ff @(posedge sys_clk or negedge rst_s2) begin
      if (!rst_s2) begin
         pin_q <= 1'h0;
         pulse_cnt <= '0;
      end else begin
         pin_q <= reset_pin;
         if (!reset_pin)
            pulse_cnt <= '0;
         else if (!pulse_long)
            pulse_cnt <= pulse_cnt + 1'b1;
      end
   end

   // configuration restored to defaults by any reset
   always_ff @(posedge sys_clk or negedge rst_s2) begin
      if (!rst_s2) begin
         cfg.edge_sel <= `CFG_EDGE_RST;
         cfg.inh_disable <= `CFG_INH_DIS_RST;
         cfg.test_en <= 1'h0;
         cfg.test_phy <= 1'h0;
      end else if (pin_reset) begin
         cfg.edge_sel <= `CFG_EDGE_RST;
         cfg.inh_disable <= `CFG_INH_DIS_RST;
         cfg.test_en <= 1'h0;
         cfg.test_phy <= 1'h0;
      end else if (cfg_wr) begin
         cfg.edge_sel <= cfg_data[`CFG_EDGE_HI:`CFG_EDGE_LO];
         cfg.inh_disable <= cfg_data[`CFG_INH_DIS_BIT];
         cfg.test_en <= cfg_data[21];
         cfg.test_phy <= cfg_data[0];
      end
   end

   // mode selection; wake leaves sleep for standby
   always_comb begin
      next_mode = mode;
      if (pin_reset)
         next_mode = sbc_wake_pkg::MODE_STANDBY;
      else if (in_sleep && (local_rouse_event || bus_wup))
         next_mode = sbc_wake_pkg::MODE_STANDBY;
      else if (mode_wr)
         next_mode = mode_req;
   end

   // decoded mode of the coming cycle
   wire next_normal = (next_mode == sbc_wake_pkg::MODE_NORMAL);
   wire next_standby = (next_mode == sbc_wake_pkg::MODE_STANDBY);
   wire next_sleep = (next_mode == sbc_wake_pkg::MODE_SLEEP);
   wire next_test = (next_mode == sbc_wake_pkg::MODE_TEST);

   wire wake_set = local_rouse_event | bus_wup;
   // a pin reset is a power-on event, so it raises the request as well
   wire wake_hold = wake_latched & ~wake_clear;
   wire next_wake_latched = wake_set | pin_reset | wake_hold;
   wire next_rouse_n = ~(wake_latched | wake_set | pin_reset);
   // the disable bit is back at its default in the reset cycle itself,
   // otherwise a reset from sleep would leave the enable off one cycle
   wire inh_dis_now = pin_reset ? `CFG_INH_DIS_RST : cfg.inh_disable;
   wire next_inh = ~next_sleep & ~inh_dis_now;
   wire dom = is_test ? test_in_pin : ctrl_node.txd;
   wire next_drive_dom = (next_normal | next_test) & ~dom;
   wire next_bias_weak = next_standby | next_sleep;
   wire next_test_out = cfg.test_phy ? phy_node.rxd : ctrl_node.txd;
   wire wait_done = (wait_cnt >= ACCESS_WAIT_CYC[$bits(wait_cnt)-1:0]);
   wire next_spi_ready = ~pin_reset & wait_done;

   // mode and wake request; set beats clear
   always_ff @(posedge sys_clk or negedge rst_s2) begin
      if (!rst_s2) begin
         mode <= sbc_wake_pkg::MODE_STANDBY;
         wake_latched <= 1'h1;
         rouse_request_n <= 1'h0;
      end else begin
         mode <= next_mode;
         wake_latched <= next_wake_latched;
         rouse_request_n <= next_rouse_n;
      end
   end

   // serial access gate after any reset
   always_ff @(posedge sys_clk or negedge rst_s2) begin
      if (!rst_s2) begin
         wait_cnt <= '0;
         spi_ready <= 1'h0;
      end else begin
         if (pin_reset)
            wait_cnt <= '0;
         else if (!spi_ready)
            wait_cnt <= wait_cnt + 1'b1;
         spi_ready <= next_spi_ready;
      end
   end

   // supplies; held on through a reset from normal or standby
   always_ff @(posedge sys_clk or negedge rst_s2) begin
      if (!rst_s2) begin
         regulator_enable_out <= 1'h1;
         regulator_enable_oe <= 1'h0;
         ldo_supply_out <= 1'h1;
      end else begin
         regulator_enable_out <= next_inh;
         regulator_enable_oe <= ~next_inh;
         ldo_supply_out <= ~next_sleep;
      end
   end

   // dominant drives low, recessive released; wired-and on bus
   always_ff @(posedge sys_clk or negedge rst_s2) begin
      if (!rst_s2) begin
         bus_drive_dom <= 1'h0;
         bus_bias_weak <= 1'h1;
         bus_rx <= 1'h1;
      end else begin
         bus_drive_dom <= next_drive_dom;
         bus_bias_weak <= next_bias_weak;
         bus_rx <= bus_level;
      end
   end

   // test pins
   always_ff @(posedge sys_clk or negedge rst_s2) begin
      if (!rst_s2) begin
         test_out_pin <= 1'h1;
         test_out_oe <= 1'h1;
      end else begin
         test_out_pin <= next_test_out;
         test_out_oe <= ~is_test;
      end
   end

   // assertions
   sequence pulse_seen;
      pin_q && !reset_pin && pulse_long;
   endsequence

   reset_to_standby_a: assert property (
      @(posedge sys_clk) disable iff (!rst_s2)
      pulse_seen |=> mode == sbc_wake_pkg::MODE_STANDBY)
      else $error("pin reset did not enter standby");

   reset_cfg_default_a: assert property (
      @(posedge sys_clk) disable iff (!rst_s2)
      pulse_seen |=> cfg.edge_sel == 2'h3 && !cfg.inh_disable)
      else $error("pin reset did not restore config");

   inh_sleep_off_a: assert property (
      @(posedge sys_clk) disable iff (!rst_s2)
      ##1 $past(next_mode) == sbc_wake_pkg::MODE_SLEEP
      |-> regulator_enable_oe)
      else $error("regulator enable driven in sleep");

   inh_disable_a: assert property (
      @(posedge sys_clk) disable iff (!rst_s2)
      cfg.inh_disable && !pin_reset |=> !regulator_enable_out)
      else $error("regulator enable not suppressed");

   inh_steady_reset_a: assert property (
      @(posedge sys_clk) disable iff (!rst_s2)
      (pulse_seen and (!in_sleep && regulator_enable_out && !cfg_wr))
      |=> regulator_enable_out && !rouse_request_n)
      else $error("outputs toggled on reset");

   sleep_reset_on_a: assert property (
      @(posedge sys_clk) disable iff (!rst_s2)
      (pulse_seen and in_sleep) |=> regulator_enable_out && !rouse_request_n)
      else $error("outputs not on after sleep reset");

   ldo_sleep_a: assert property (
      @(posedge sys_clk) disable iff (!rst_s2)
      mode_wr && mode_req == sbc_wake_pkg::MODE_SLEEP && !pin_reset
      && !(in_sleep && wake_set) |=> !ldo_supply_out)
      else $error("supply regulator on in sleep");

   wake_request_a: assert property (
      @(posedge sys_clk) disable iff (!rst_s2)
      wake_set |=> !rouse_request_n [*2])
      else $error("wake request not asserted");

   spi_wait_a: assert property (
      @(posedge sys_clk) disable iff (!rst_s2)
      pin_reset |=> !spi_ready [*8])
      else $error("serial ready too early after reset");

   bus_rx_high_a: assert property (
      @(posedge sys_clk) disable iff (!rst_s2)
      bus_level |=> bus_rx)
      else $error("recessive level not seen as high");

   bus_rx_low_a: assert property (
      @(posedge sys_clk) disable iff (!rst_s2)
      !bus_level |=> !bus_rx)
      else $error("dominant level not seen as low");

   dominant_drive_a: assert property (
      @(posedge sys_clk) disable iff (!rst_s2)
      mode == sbc_wake_pkg::MODE_NORMAL && !mode_wr && !pin_reset
      && !ctrl_node.txd |=> bus_drive_dom)
      else $error("dominant bit not driven");

   standby_bias_a: assert property (
      @(posedge sys_clk) disable iff (!rst_s2)
      mode == sbc_wake_pkg::MODE_STANDBY && !mode_wr |=> bus_bias_weak)
      else $error("standby bus not weakly biased");

   test_oe_on_a: assert property (
      @(posedge sys_clk) disable iff (!rst_s2)
      is_test |=> !test_out_oe)
      else $error("test pin not driven in test mode");

   ldo_wake_on_a: assert property (
      @(posedge sys_clk) disable iff (!rst_s2)
      in_sleep && wake_set
      |=> ldo_supply_out && mode == sbc_wake_pkg::MODE_STANDBY)
      else $error("supply regulator off after wake");

   sequence wake_rise;
      !wake_pin ##1 wake_pin && cfg.edge_sel[0];
   endsequence

   sequence wake_fall;
      wake_pin ##1 !wake_pin && cfg.edge_sel[1];
   endsequence

   local_wake_a: assert property (
      @(posedge sys_clk) disable iff (!rst_s2)
      (wake_rise or wake_fall) |=> ##1 !rouse_request_n)
      else $error("local wake edge not requested");

   wake_off_a: assert property (
      @(posedge sys_clk) disable iff (!rst_s2)
      cfg.edge_sel == 2'h0 |=> !local_rouse_event)
      else $error("local wake seen while disabled");
endmodule : sbc_wake_inhibit_reset_control

// *** tb/host_model.sv ***
// host processor model: drives the reset pin and the local wake pin
module host_model (
   // clock
   input wire logic sys_clk,
   // device status
   input wire logic spi_ready,
   // pins driven by the host
   output logic reset_pin,
   output logic wake_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      reset_pin = 1'h0;
      wake_pin = 1'h0;
   end
   // a pulse shorter than the minimum width is ignored by the device
   task automatic pulse_reset(input int cycles);
      @(posedge sys_clk);
      reset_pin <= 1'h1;
      repeat (cycles) @(posedge sys_clk);
      reset_pin <= 1'h0;
   endtask : pulse_reset
   task automatic set_wake(input logic level);
      @(posedge sys_clk);
      wake_pin <= level;
   endtask : set_wake
   // serial clock rate and oscillator choice stay with the host
   // no serial access before the device reports the wait has run out
   task automatic wait_ready(input int limit, output logic ok);
      ok = 1'h0;
      for (int i = 0; i < limit && !ok; i++) begin
         @(posedge sys_clk);
         #1;
         ok = (spi_ready === 1'h1);
      end
   endtask : wait_ready
endmodule : host_model

// *** tb/tb.sv ***
// self-checking bench for the wake, inhibit and reset control block
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PULSE = 8;
   localparam int WAIT = 20;
   logic sys_clk, rst_b, reset_pin, mode_wr, cfg_wr, wake_pin, bus_wup;
   logic wake_clear, test_in_pin, bus_level, bus_drive_dom, bus_bias_weak;
   logic bus_rx, test_out_pin, test_out_oe, regulator_enable_out;
   logic regulator_enable_oe, ldo_supply_out, rouse_request_n, spi_ready, ok;
   logic [31:0] cfg_data;
   sbc_wake_pkg::mode_t mode_req, mode;
   sbc_wake_pkg::node_pair_t ctrl_node, phy_node;
   int n_mismatch = 0;
   int n_checks = 0;

   host_model host (.sys_clk(sys_clk), .spi_ready(spi_ready),
      .reset_pin(reset_pin), .wake_pin(wake_pin));
   sbc_wake_inhibit_reset_control #(.PULSE_CYC(PULSE),
      .ACCESS_WAIT_CYC(WAIT)) dut (.sys_clk(sys_clk), .rst_b(rst_b),
      .reset_pin(reset_pin), .mode_wr(mode_wr), .mode_req(mode_req),
      .cfg_wr(cfg_wr), .cfg_data(cfg_data), .wake_pin(wake_pin),
      .bus_wup(bus_wup), .wake_clear(wake_clear), .ctrl_node(ctrl_node),
      .phy_node(phy_node), .test_in_pin(test_in_pin),
      .bus_drive_dom(bus_drive_dom), .bus_bias_weak(bus_bias_weak),
      .bus_rx(bus_rx), .bus_level(bus_level), .test_out_pin(test_out_pin),
      .test_out_oe(test_out_oe),
      .regulator_enable_out(regulator_enable_out),
      .regulator_enable_oe(regulator_enable_oe),
      .ldo_supply_out(ldo_supply_out), .rouse_request_n(rouse_request_n),
      .spi_ready(spi_ready), .mode(mode));

   initial begin
      sys_clk = 1'h0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   task automatic tally_and_finish;
      $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : step

   task automatic set_mode(input sbc_wake_pkg::mode_t m);
      @(posedge sys_clk);
      mode_wr <= 1'h1;
      mode_req <= m;
      @(posedge sys_clk);
      mode_wr <= 1'h0;
      step(2);
   endtask : set_mode

   task automatic set_cfg(input logic [31:0] d);
      @(posedge sys_clk);
      cfg_wr <= 1'h1;
      cfg_data <= d;
      @(posedge sys_clk);
      cfg_wr <= 1'h0;
      step(2);
   endtask : set_cfg

   // clear the latch, move the wake pin, then look for a request
   task automatic try_wake(input logic level, input logic hit);
      @(posedge sys_clk);
      wake_clear <= 1'h1;
      @(posedge sys_clk);
      wake_clear <= 1'h0;
      step(2);
      chk(rouse_request_n, 1'h1);
      host.set_wake(level);
      for (int i = 0; i < 8 && rouse_request_n !== 1'h0; i++) step(1);
      chk(rouse_request_n, {31'h0, !hit});
   endtask : try_wake

   task automatic t_modes;
      chk(mode, sbc_wake_pkg::MODE_STANDBY);
      chk(rouse_request_n, 1'h0);
      set_mode(sbc_wake_pkg::MODE_SLEEP);
      chk(regulator_enable_oe, 1'h1);
      chk(ldo_supply_out, 1'h0);
      chk(bus_bias_weak, 1'h1);
      set_mode(sbc_wake_pkg::MODE_NORMAL);
      chk(regulator_enable_out & ~regulator_enable_oe, 1'h1);
      chk(ldo_supply_out, 1'h1);
      ctrl_node.txd <= 1'h0;
      bus_level <= 1'h0;
      step(2);
      chk({bus_drive_dom, bus_rx}, 2'h2);
      ctrl_node.txd <= 1'h1;
      bus_level <= 1'h1;
      step(2);
      chk({bus_drive_dom, bus_rx}, 2'h1);
   endtask : t_modes

   task automatic t_wake;
      for (int e = 3; e >= 0; e--) begin
         set_cfg({e[1:0], 30'h0});
         try_wake(1'h1, e[0]);
         try_wake(1'h0, e[1]);
      end
      try_wake(1'h0, 1'h0);
      bus_wup <= 1'h1;
      step(1);
      bus_wup <= 1'h0;
      step(3);
      chk(rouse_request_n, 1'h0);
   endtask : t_wake

   task automatic t_test_inh;
      set_cfg(32'h0020_0000);
      set_mode(sbc_wake_pkg::MODE_TEST);
      chk(test_out_oe, 1'h0);
      ctrl_node.txd <= 1'h0;
      test_in_pin <= 1'h1;
      step(2);
      chk({test_out_pin, bus_drive_dom}, 2'h0);
      set_cfg(32'h0020_0001);
      chk(test_out_pin, 1'h1);
      phy_node.rxd <= 1'h0;
      step(2);
      chk(test_out_pin, 1'h0);
      ctrl_node.txd <= 1'h1;
      set_mode(sbc_wake_pkg::MODE_NORMAL);
      chk(test_out_oe, 1'h1);
      set_cfg(32'h0000_0200);
      chk(regulator_enable_out & ~regulator_enable_oe, 1'h0);
   endtask : t_test_inh

   task automatic t_reset;
      logic bad;
      set_cfg(32'h0000_0000);
      bad = 1'h0;
      fork
         host.pulse_reset(PULSE + 2);
         repeat (PULSE + 6) begin
            step(1);
            if (regulator_enable_out !== 1'h1 || rouse_request_n !== 1'h0)
               bad = 1'h1;
         end
      join
      chk(bad, 1'h0);
      set_cfg(32'h4000_0200);
      set_mode(sbc_wake_pkg::MODE_SLEEP);
      host.pulse_reset(PULSE + 2);
      step(3);
      chk(mode, sbc_wake_pkg::MODE_STANDBY);
      chk(regulator_enable_out & ~regulator_enable_oe, 1'h1);
      chk(rouse_request_n, 1'h0);
      chk(spi_ready, 1'h0);
      host.wait_ready(WAIT + 10, ok);
      chk(ok, 1'h1);
      try_wake(1'h1, 1'h1);
      try_wake(1'h0, 1'h1);
   endtask : t_reset

   initial begin
      #200000;
      n_mismatch++;
      tally_and_finish;
   end

   initial begin
      rst_b = 1'h0;
      mode_wr = 1'h0;
      mode_req = sbc_wake_pkg::MODE_STANDBY;
      cfg_wr = 1'h0;
      cfg_data = 32'h0;
      bus_wup = 1'h0;
      wake_clear = 1'h0;
      test_in_pin = 1'h0;
      bus_level = 1'h1;
      ctrl_node = 2'h3;
      phy_node = 2'h3;
      repeat (16) @(posedge sys_clk);
      rst_b <= 1'h1;
      step(4);
      t_modes;
      t_wake;
      t_test_inh;
      t_reset;
      tally_and_finish;
   end
endmodule : tb
